// File: logic/acq_decim.sv
`timescale 1ns/1ps
module acq_decim (
	input wire logic clk,
	input wire logic rst,
	input wire logic [1:0] log2_ratio,
	input wire logic in_valid,
	input wire logic [acq_pkg::SMP_W-1:0] in_data,
	input wire logic [acq_pkg::QID_W-1:0] in_queue,
	output logic out_valid,
	output logic [acq_pkg::SMP_W-1:0] out_data,
	output logic [acq_pkg::QID_W-1:0] out_queue
);
	logic [acq_pkg::DEC_CNT_W-1:0] cnt_q;
	logic [acq_pkg::DEC_ACC_W-1:0] acc_q;
	logic out_valid_q;
	logic [acq_pkg::SMP_W-1:0] out_data_q;
	logic [acq_pkg::QID_W-1:0] out_queue_q;
	wire [acq_pkg::DEC_ACC_W-1:0] sum;
	wire [acq_pkg::DEC_ACC_W-1:0] avg;
	wire [acq_pkg::DEC_CNT_W-1:0] last;

	// A boxcar average over 2**log2_ratio samples, then one output per block.
	assign sum = acc_q + acq_pkg::DEC_ACC_W'(in_data);
	assign avg = sum >> log2_ratio;
	assign last = acq_pkg::DEC_CNT_W'((4'h1 << log2_ratio) - 4'h1);
	assign out_valid = out_valid_q;
	assign out_data = out_data_q;
	assign out_queue = out_queue_q;

	always_ff @(posedge clk) begin
		if (rst) begin
			cnt_q <= '0;
			acc_q <= '0;
			out_valid_q <= 1'b0;
			out_data_q <= '0;
			out_queue_q <= '0;
		end else begin
			out_valid_q <= 1'b0;
			if (in_valid && cnt_q == last) begin
				out_valid_q <= 1'b1; // R09
				out_data_q <= avg[acq_pkg::SMP_W-1:0];
				out_queue_q <= in_queue;
				cnt_q <= '0;
				acc_q <= '0;
			end else if (in_valid) begin
				cnt_q <= cnt_q + 3'h1;
				acc_q <= sum;
			end
		end
	end
endmodule : acq_decim

// File: logic/acq_fifo.sv
`timescale 1ns/1ps
module acq_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 16,
	parameter int CNT_W = 5
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic in_valid,
	input wire logic [WIDTH-1:0] in_data,
	output logic in_ready,
	output logic out_valid,
	output logic [WIDTH-1:0] out_data,
	input wire logic out_ready,
	output logic [CNT_W-1:0] count
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr_q;
	logic [AW-1:0] rd_ptr_q;
	logic [CNT_W-1:0] mem_cnt_q;
	logic out_valid_q;
	logic [WIDTH-1:0] out_data_q;
	wire wr_fire;
	wire load;

	// Storage drains into the output register whenever it is empty or being taken.
	assign in_ready = (mem_cnt_q != CNT_W'(DEPTH));
	assign wr_fire = in_valid && in_ready;
	assign load = (mem_cnt_q != '0) && (!out_valid_q || out_ready);
	assign out_valid = out_valid_q;
	assign out_data = out_data_q;
	assign count = mem_cnt_q + CNT_W'(out_valid_q);

	always_ff @(posedge clk) begin
		if (wr_fire) begin
			mem[wr_ptr_q] <= in_data;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			mem_cnt_q <= '0;
			out_valid_q <= 1'b0;
			out_data_q <= '0;
		end else begin
			wr_ptr_q <= wr_ptr_q + AW'(wr_fire);
			rd_ptr_q <= rd_ptr_q + AW'(load);
			mem_cnt_q <= mem_cnt_q + CNT_W'(wr_fire) - CNT_W'(load);
			if (load) begin
				out_data_q <= mem[rd_ptr_q];
				out_valid_q <= 1'b1;
			end else if (out_ready) begin
				out_valid_q <= 1'b0;
			end
		end
	end
endmodule : acq_fifo

// File: logic/acq_pkg.sv
package acq_pkg;
	localparam int NUM_Q = 6;
	localparam int QID_W = 3;
	localparam int NUM_ADC = 2;
	localparam int NUM_SRC = 3;
	localparam int CMD_W = 16;
	localparam int RES_W = 16;
	localparam int SMP_W = 12;
	localparam int CHAN_W = 6;
	localparam int FIFO_DEPTH = 16;
	localparam int FIFO_CNT_W = 5;

	// Command word layout.
	localparam int CMD_EXT_BIT = 15;
	localparam int CMD_ADC_BIT = 14;
	localparam int CMD_CHAN_LSB = 8;
	localparam int CMD_RQ_LSB = 5;
	localparam int CMD_DEC_BIT = 4;

	// Result word layout: source in the top two bits, sample in the low bits.
	localparam int RES_SRC_LSB = 14;
	localparam logic [1:0] SRC_EXT = 2'h2;
	localparam logic [1:0] SRC_DEC = 2'h3;

	// Fill thresholds for the transfer requests.
	localparam logic [FIFO_CNT_W-1:0] CMD_LOW_WM = 5'h04;
	localparam logic [FIFO_CNT_W-1:0] RES_HIGH_WM = 5'h08;
	localparam logic [FIFO_CNT_W-1:0] FIFO_READY_MAX = 5'h0E;

	// Serial link timing.
	localparam int CLK_PERIOD_PS = 25000;
	localparam int SER_HALF_PS = 100000;
	localparam int SER_DIV_W = 4;
	localparam logic [SER_DIV_W-1:0] SER_HALF_CYC =
		SER_DIV_W'((SER_HALF_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
	localparam int SER_CNT_W = 6;
	localparam logic [SER_CNT_W-1:0] SER_FRAME_BITS = 6'h20;
	localparam int SER_SHIFT_W = 32;

	// Decimation stage.
	localparam int DEC_CNT_W = 3;
	localparam int DEC_ACC_W = 15;

	typedef enum logic [1:0] {
		ACQ_SER_IDLE = 2'h0,
		ACQ_SER_SHIFT = 2'h1,
		ACQ_SER_DONE = 2'h3
	} acq_ser_state_t;
endpackage : acq_pkg

// File: logic/acq_queue_ctrl.sv
// Contract
// R01 - Six command queues; queue 0 ranks highest, queue 5 lowest.
// R02 - Queue 0 commands bypass waiting, abort a running on-chip conversion, start at once.
// R03 - Queue 0 trigger to conversion start takes a fixed delay regardless of activity.
// R04 - Commands go to either on-chip converter or over the serial link.
// R05 - Results enter six result queues independently of command processing.
// R06 - Transfers start on software or hardware triggers.
// R07 - Queue fill levels raise DMA or interrupt requests.
// R08 - Either on-chip converter converts any analog channel named in a command.
// R09 - Optional decimation filters, downsamples, then writes results to result queues.
// R10 - A free converter takes from the highest-priority triggered queue with a command.
`timescale 1ns/1ps
module acq_queue_ctrl (
	input wire logic CLK,
	input wire logic SYS_RST,
	input wire logic CMD_WR_VALID,
	input wire logic [acq_pkg::QID_W-1:0] CMD_WR_QUEUE,
	input wire logic [acq_pkg::CMD_W-1:0] CMD_WR_DATA,
	output logic [acq_pkg::NUM_Q-1:0] CMD_WR_READY,
	input wire logic [acq_pkg::NUM_Q-1:0] SW_TRIG,
	input wire logic [acq_pkg::NUM_Q-1:0] HW_TRIG,
	input wire logic [acq_pkg::NUM_Q-1:0] REQ_USE_DMA,
	input wire logic [1:0] DECIM_LOG2,
	output logic [acq_pkg::NUM_ADC-1:0] ADC_START,
	output logic [acq_pkg::NUM_ADC-1:0] ADC_ABORT,
	output logic [acq_pkg::CHAN_W-1:0] ADC_CHAN0,
	output logic [acq_pkg::CHAN_W-1:0] ADC_CHAN1,
	input wire logic [acq_pkg::NUM_ADC-1:0] ADC_DONE,
	input wire logic [acq_pkg::SMP_W-1:0] ADC_DATA0,
	input wire logic [acq_pkg::SMP_W-1:0] ADC_DATA1,
	output logic SER_SCK,
	output logic SER_CS_N,
	output logic SER_MOSI,
	input wire logic SER_MISO,
	output logic [acq_pkg::NUM_Q-1:0] CMD_DMA_REQ,
	output logic [acq_pkg::NUM_Q-1:0] CMD_IRQ,
	output logic [acq_pkg::NUM_Q-1:0] RES_DMA_REQ,
	output logic [acq_pkg::NUM_Q-1:0] RES_IRQ,
	input wire logic [acq_pkg::NUM_Q-1:0] RES_RD_READY,
	output logic [acq_pkg::NUM_Q-1:0] RES_RD_VALID,
	output logic [acq_pkg::NUM_Q*acq_pkg::RES_W-1:0] RES_RD_DATA,
	output logic RES_OVERRUN
);
	localparam int NQ = acq_pkg::NUM_Q;
	localparam int NS = acq_pkg::NUM_SRC;

	// Command side.
	logic [acq_pkg::CMD_W-1:0] head [NQ];
	logic [NQ-1:0] head_valid;
	logic [acq_pkg::FIFO_CNT_W-1:0] cmd_cnt [NQ];
	logic [NQ-1:0] cmd_push;
	logic [NQ-1:0] pop;
	logic [NQ-1:0] armed_q;
	logic [NQ-1:0] armed_now;
	logic [NQ-1:0] cand;
	logic [NQ-1:0] wr_ready_q;
	logic [NQ-1:0] cmd_dma_q;
	logic [NQ-1:0] cmd_irq_q;
	logic [NQ-1:0] res_dma_q;
	logic [NQ-1:0] res_irq_q;
	logic gnt_v;
	logic [acq_pkg::QID_W-1:0] gnt;

	// Converter side.
	logic [acq_pkg::NUM_ADC-1:0] adc_busy_q;
	logic [acq_pkg::NUM_ADC-1:0] adc_start_q;
	logic [acq_pkg::NUM_ADC-1:0] adc_abort_q;
	logic [acq_pkg::CHAN_W-1:0] adc_chan_q [acq_pkg::NUM_ADC];
	logic [acq_pkg::QID_W-1:0] adc_rq_q [acq_pkg::NUM_ADC];
	logic [acq_pkg::NUM_ADC-1:0] adc_dec_q;

	// Serial link.
	acq_pkg::acq_ser_state_t ser_state_q;
	logic [acq_pkg::SER_DIV_W-1:0] ser_div_q;
	logic [acq_pkg::SER_CNT_W-1:0] ser_bits_q;
	logic [acq_pkg::SER_SHIFT_W-1:0] ser_tx_q;
	logic [acq_pkg::SMP_W-1:0] ser_rx_q;
	logic [acq_pkg::QID_W-1:0] ser_rq_q;
	logic ser_dec_q;
	logic ser_sck_q;
	logic ser_cs_n_q;
	logic miso_m_q;
	logic miso_s_q;
	wire ser_tick;
	wire ser_fall;

	// Result side: one hold slot per source.
	logic [NS-1:0] pend_v_q;
	logic [acq_pkg::SMP_W-1:0] pend_d_q [NS];
	logic [acq_pkg::QID_W-1:0] pend_rq_q [NS];
	logic [NS-1:0] pend_dec_q;
	logic [NS-1:0] src_done;
	logic [acq_pkg::SMP_W-1:0] src_d [NS];
	logic [acq_pkg::QID_W-1:0] src_rq [NS];
	logic [NS-1:0] src_dec;
	logic [NS-1:0] pend_ok;
	logic rsel_v;
	logic [1:0] rsel;
	logic [NQ-1:0] res_ready;
	logic [NQ-1:0] res_push;
	logic [acq_pkg::RES_W-1:0] res_word;
	logic [acq_pkg::FIFO_CNT_W-1:0] res_cnt [NQ];
	logic overrun_q;
	logic dec_out_v;
	logic [acq_pkg::SMP_W-1:0] dec_out_d;
	logic [acq_pkg::QID_W-1:0] dec_out_q;
	wire dec_in_v;
	wire [acq_pkg::QID_W-1:0] wr_queue;

	genvar i;
	generate
		for (i = 0; i < NQ; i++) begin : g_q
			wire ext = head[i][acq_pkg::CMD_EXT_BIT];
			wire sel = head[i][acq_pkg::CMD_ADC_BIT];
			wire adc_free = (i == 0) || (!adc_busy_q[sel] && !pend_v_q[sel]); // R02
			wire ser_free = (ser_state_q == acq_pkg::ACQ_SER_IDLE) && !pend_v_q[2];

			assign cmd_push[i] = CMD_WR_VALID && wr_ready_q[i] && CMD_WR_QUEUE == acq_pkg::QID_W'(i);
			assign armed_now[i] = armed_q[i] || SW_TRIG[i] || HW_TRIG[i]; // R06
			assign cand[i] = armed_now[i] && head_valid[i] && (ext ? ser_free : adc_free); // R10
			assign pop[i] = gnt_v && gnt == acq_pkg::QID_W'(i);
			assign res_push[i] = (dec_out_v && dec_out_q == acq_pkg::QID_W'(i) && res_ready[i]) ||
				(rsel_v && !pend_dec_q[rsel] && pend_rq_q[rsel] == acq_pkg::QID_W'(i)); // R05

			acq_fifo #(.WIDTH(acq_pkg::CMD_W), .DEPTH(acq_pkg::FIFO_DEPTH),
				.CNT_W(acq_pkg::FIFO_CNT_W)) u_cmd (
				.clk(CLK), .rst(SYS_RST), .in_valid(cmd_push[i]), .in_data(CMD_WR_DATA),
				.in_ready(), .out_valid(head_valid[i]), .out_data(head[i]),
				.out_ready(pop[i]), .count(cmd_cnt[i])); // R01

			acq_fifo #(.WIDTH(acq_pkg::RES_W), .DEPTH(acq_pkg::FIFO_DEPTH),
				.CNT_W(acq_pkg::FIFO_CNT_W)) u_res (
				.clk(CLK), .rst(SYS_RST), .in_valid(res_push[i]), .in_data(res_word),
				.in_ready(res_ready[i]), .out_valid(RES_RD_VALID[i]),
				.out_data(RES_RD_DATA[i*acq_pkg::RES_W +: acq_pkg::RES_W]),
				.out_ready(RES_RD_READY[i]), .count(res_cnt[i]));

			always_ff @(posedge CLK) begin
				if (SYS_RST) begin
					armed_q[i] <= 1'b0;
					wr_ready_q[i] <= 1'b0;
					cmd_dma_q[i] <= 1'b0;
					cmd_irq_q[i] <= 1'b0;
					res_dma_q[i] <= 1'b0;
					res_irq_q[i] <= 1'b0;
				end else begin
					// A queue stays triggered until it runs dry; a new trigger wins.
					armed_q[i] <= armed_now[i] && (head_valid[i] || cmd_push[i] ||
						SW_TRIG[i] || HW_TRIG[i]);
					wr_ready_q[i] <= cmd_cnt[i] <= acq_pkg::FIFO_READY_MAX;
					cmd_dma_q[i] <= cmd_cnt[i] < acq_pkg::CMD_LOW_WM && REQ_USE_DMA[i]; // R07
					cmd_irq_q[i] <= cmd_cnt[i] < acq_pkg::CMD_LOW_WM && !REQ_USE_DMA[i]; // R07
					res_dma_q[i] <= res_cnt[i] >= acq_pkg::RES_HIGH_WM && REQ_USE_DMA[i]; // R07
					res_irq_q[i] <= res_cnt[i] >= acq_pkg::RES_HIGH_WM && !REQ_USE_DMA[i]; // R07
				end
			end
		end
	endgenerate

	// Fixed-priority pick: the lowest queue index that can go wins.
	always_comb begin
		gnt_v = 1'b0;
		gnt = '0;
		for (int q = NQ - 1; q >= 0; q--) begin
			if (cand[q]) begin
				gnt_v = 1'b1; // R01
				gnt = acq_pkg::QID_W'(q);
			end
		end
	end

	wire [acq_pkg::CMD_W-1:0] gcmd = head[gnt];
	wire g_ext = gcmd[acq_pkg::CMD_EXT_BIT];
	wire g_sel = gcmd[acq_pkg::CMD_ADC_BIT];

	// Converter issue: queue 0 reaches ADC_START one edge after its trigger.
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			adc_busy_q <= '0;
			adc_start_q <= '0;
			adc_abort_q <= '0;
			adc_dec_q <= '0;
			for (int a = 0; a < acq_pkg::NUM_ADC; a++) begin
				adc_chan_q[a] <= '0;
				adc_rq_q[a] <= '0;
			end
		end else begin
			adc_start_q <= '0;
			adc_abort_q <= '0;
			adc_busy_q <= adc_busy_q & ~ADC_DONE;
			if (gnt_v && !g_ext) begin
				adc_start_q[g_sel] <= 1'b1; // R04 R03
				adc_abort_q[g_sel] <= adc_busy_q[g_sel] && !ADC_DONE[g_sel]; // R02
				adc_busy_q[g_sel] <= 1'b1;
				adc_chan_q[g_sel] <= gcmd[acq_pkg::CMD_CHAN_LSB +: acq_pkg::CHAN_W]; // R08
				adc_rq_q[g_sel] <= gcmd[acq_pkg::CMD_RQ_LSB +: acq_pkg::QID_W];
				adc_dec_q[g_sel] <= gcmd[acq_pkg::CMD_DEC_BIT];
			end
		end
	end

	// Serial master: 32 clocks per frame, command out first, result in last.
	assign ser_tick = (ser_div_q == '0);
	assign ser_fall = ser_tick && ser_sck_q;

	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			miso_m_q <= 1'b0;
			miso_s_q <= 1'b0;
		end else begin
			miso_m_q <= SER_MISO;
			miso_s_q <= miso_m_q;
		end
	end

	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			ser_state_q <= acq_pkg::ACQ_SER_IDLE;
			ser_div_q <= '0;
			ser_bits_q <= '0;
			ser_tx_q <= '0;
			ser_rx_q <= '0;
			ser_rq_q <= '0;
			ser_dec_q <= 1'b0;
			ser_sck_q <= 1'b0;
			ser_cs_n_q <= 1'b1;
		end else begin
			case (ser_state_q)
				acq_pkg::ACQ_SER_IDLE: begin
					if (gnt_v && g_ext) begin
						ser_state_q <= acq_pkg::ACQ_SER_SHIFT; // R04
						ser_tx_q <= {gcmd, 16'h0000};
						ser_rq_q <= gcmd[acq_pkg::CMD_RQ_LSB +: acq_pkg::QID_W];
						ser_dec_q <= gcmd[acq_pkg::CMD_DEC_BIT];
						ser_div_q <= acq_pkg::SER_HALF_CYC - 4'h1;
						ser_bits_q <= '0;
						ser_cs_n_q <= 1'b0;
					end
				end
				acq_pkg::ACQ_SER_SHIFT: begin
					ser_div_q <= ser_tick ? acq_pkg::SER_HALF_CYC - 4'h1 : ser_div_q - 4'h1;
					if (ser_tick) begin
						ser_sck_q <= !ser_sck_q;
					end
					if (ser_fall) begin
						ser_tx_q <= {ser_tx_q[acq_pkg::SER_SHIFT_W-2:0], 1'b0};
						ser_rx_q <= {ser_rx_q[acq_pkg::SMP_W-2:0], miso_s_q};
						ser_bits_q <= ser_bits_q + 6'h01;
						if (ser_bits_q == acq_pkg::SER_FRAME_BITS - 6'h01) begin
							ser_state_q <= acq_pkg::ACQ_SER_DONE;
							ser_cs_n_q <= 1'b1;
						end
					end
				end
				acq_pkg::ACQ_SER_DONE: begin
					ser_state_q <= acq_pkg::ACQ_SER_IDLE;
				end
				default: begin
					ser_state_q <= acq_pkg::ACQ_SER_IDLE;
				end
			endcase
		end
	end

	// Result collection, running beside the command path.
	assign src_done = {ser_state_q == acq_pkg::ACQ_SER_DONE, ADC_DONE};
	assign src_d[0] = ADC_DATA0;
	assign src_d[1] = ADC_DATA1;
	assign src_d[2] = ser_rx_q;
	assign src_rq[0] = adc_rq_q[0];
	assign src_rq[1] = adc_rq_q[1];
	assign src_rq[2] = ser_rq_q;
	assign src_dec = {ser_dec_q, adc_dec_q};

	// Decimated output owns the write slot; otherwise the lowest ready source goes.
	always_comb begin
		rsel_v = 1'b0;
		rsel = '0;
		for (int s = NS - 1; s >= 0; s--) begin
			pend_ok[s] = pend_v_q[s] && (pend_dec_q[s] || res_ready[pend_rq_q[s]]);
			if (pend_ok[s] && !dec_out_v) begin
				rsel_v = 1'b1;
				rsel = 2'(s);
			end
		end
	end

	assign dec_in_v = rsel_v && pend_dec_q[rsel]; // R09
	assign wr_queue = dec_out_v ? dec_out_q : pend_rq_q[rsel];
	assign res_word = dec_out_v ? {acq_pkg::SRC_DEC, 2'b00, dec_out_d} :
		{rsel, 2'b00, pend_d_q[rsel]};

	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			pend_v_q <= '0;
			pend_dec_q <= '0;
			overrun_q <= 1'b0;
			for (int s = 0; s < NS; s++) begin
				pend_d_q[s] <= '0;
				pend_rq_q[s] <= '0;
			end
		end else begin
			overrun_q <= (|(src_done & pend_v_q & ~({NS{rsel_v}} & (3'b001 << rsel)))) ||
				(dec_out_v && !res_ready[wr_queue]);
			for (int s = 0; s < NS; s++) begin
				if (rsel_v && rsel == 2'(s)) begin
					pend_v_q[s] <= 1'b0;
				end
				if (src_done[s] && (!pend_v_q[s] || (rsel_v && rsel == 2'(s)))) begin
					pend_v_q[s] <= 1'b1; // R05
					pend_d_q[s] <= src_d[s];
					pend_rq_q[s] <= src_rq[s];
					pend_dec_q[s] <= src_dec[s];
				end
			end
		end
	end

	acq_decim u_decim (
		.clk(CLK),
		.rst(SYS_RST),
		.log2_ratio(DECIM_LOG2),
		.in_valid(dec_in_v),
		.in_data(pend_d_q[rsel]),
		.in_queue(pend_rq_q[rsel]),
		.out_valid(dec_out_v),
		.out_data(dec_out_d),
		.out_queue(dec_out_q)
	);

	assign CMD_WR_READY = wr_ready_q;
	assign ADC_START = adc_start_q;
	assign ADC_ABORT = adc_abort_q;
	assign ADC_CHAN0 = adc_chan_q[0];
	assign ADC_CHAN1 = adc_chan_q[1];
	assign SER_SCK = ser_sck_q;
	assign SER_CS_N = ser_cs_n_q;
	assign SER_MOSI = ser_tx_q[acq_pkg::SER_SHIFT_W-1];
	assign CMD_DMA_REQ = cmd_dma_q;
	assign CMD_IRQ = cmd_irq_q;
	assign RES_DMA_REQ = res_dma_q;
	assign RES_IRQ = res_irq_q;
	assign RES_OVERRUN = overrun_q;
endmodule : acq_queue_ctrl

// File: testbench/acq_conv_model.sv
`timescale 1ns/1ps
module acq_conv_model #(
	parameter int CONV_CYC = 20,
	parameter logic [11:0] SER_RESULT = 12'h5A3
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [1:0] start,
	input wire logic [5:0] chan0,
	input wire logic [5:0] chan1,
	output logic [1:0] done,
	output logic [11:0] data0,
	output logic [11:0] data1,
	input wire logic sck,
	input wire logic cs_n,
	input wire logic mosi,
	output logic miso,
	output logic [31:0] rx
);
	int cnt [2];
	logic [5:0] ch [2];
	logic [31:0] tx;
	logic sck_q;
	logic miso_q;
	// A new start restarts the converter, so an aborted result is never delivered.
	always_ff @(posedge clk) begin
		for (int i = 0; i < 2; i++) begin
			done[i] <= 1'b0;
			if (rst) begin
				cnt[i] <= 0;
			end else if (start[i]) begin
				cnt[i] <= CONV_CYC;
				ch[i] <= i ? chan1 : chan0;
			end else if (cnt[i] == 1) begin
				cnt[i] <= 0;
				done[i] <= 1'b1;
			end else if (cnt[i] != 0) begin
				cnt[i] <= cnt[i] - 1;
			end
		end
	end
	// Data lines carry the inverse of the result outside the done cycle.
	assign data0 = done[0] ? {ch[0], ch[0] ^ 6'h2A} : ~{ch[0], ch[0] ^ 6'h2A};
	assign data1 = done[1] ? {ch[1], ch[1] ^ 6'h2A} : ~{ch[1], ch[1] ^ 6'h2A};
	// The slave shifts after each falling serial clock and toggles its line when deselected.
	always_ff @(posedge clk) begin
		sck_q <= sck;
		miso_q <= rst ? 1'b0 : miso;
		if (cs_n) begin
			tx <= {20'h00000, SER_RESULT};
		end else if (sck_q && !sck) begin
			tx <= {tx[30:0], 1'b0};
		end
		if (!cs_n && !sck_q && sck) begin
			rx <= {rx[30:0], mosi};
		end
	end
	assign miso = cs_n ? ~miso_q : tx[31];
endmodule : acq_conv_model

// File: testbench/acq_qc_assertions.sv
`timescale 1ns/1ps
module acq_qc_assertions (
	input wire logic CLK,
	input wire logic SYS_RST,
	input wire logic [5:0] REQ_USE_DMA,
	input wire logic [1:0] ADC_START,
	input wire logic [1:0] ADC_ABORT,
	input wire logic SER_SCK,
	input wire logic SER_CS_N,
	input wire logic SER_MOSI,
	input wire logic [5:0] CMD_DMA_REQ,
	input wire logic [5:0] CMD_IRQ,
	input wire logic [5:0] RES_DMA_REQ,
	input wire logic [5:0] RES_IRQ,
	input wire logic [5:0] RES_RD_READY,
	input wire logic [5:0] RES_RD_VALID,
	input wire logic [95:0] RES_RD_DATA
);
	logic [5:0] rise_q;
	default clocking @(posedge CLK);
	endclocking
	default disable iff (SYS_RST);
	// Counts serial clock rises inside one select window.
	always_ff @(posedge CLK) begin
		if (SYS_RST || SER_CS_N) begin
			rise_q <= 6'h00;
		end else if ($rose(SER_SCK)) begin
			rise_q <= rise_q + 6'h01;
		end
	end
	property p_idle; SER_CS_N |-> !SER_SCK; endproperty
	a_idle: assert property (p_idle) else $error("serial clock while idle");
	property p_lead; $fell(SER_CS_N) |-> (!SER_SCK) [*4] ##1 SER_SCK; endproperty
	a_lead: assert property (p_lead) else $error("first serial rise misplaced");
	property p_high; $rose(SER_SCK) |-> SER_SCK [*4] ##1 !SER_SCK; endproperty
	a_high: assert property (p_high) else $error("serial high phase length");
	property p_mosi; SER_SCK |-> $stable(SER_MOSI); endproperty
	a_mosi: assert property (p_mosi) else $error("data out moved while clock high");
	property p_len; $rose(SER_CS_N) |-> rise_q == 6'h20; endproperty
	a_len: assert property (p_len) else $error("frame length wrong");
	property p_abort; ADC_ABORT != 2'h0 |-> (ADC_ABORT & ~ADC_START) == 2'h0; endproperty
	a_abort: assert property (p_abort) else $error("abort without start");
	property p_one; ADC_START != 2'h0 |-> $onehot(ADC_START); endproperty
	a_one: assert property (p_one) else $error("two starts in one cycle");
	property p_croute;
		((CMD_DMA_REQ & ~$past(REQ_USE_DMA)) | (CMD_IRQ & $past(REQ_USE_DMA))) == 6'h00;
	endproperty
	a_croute: assert property (p_croute) else $error("command request misrouted");
	property p_rroute;
		((RES_DMA_REQ & ~$past(REQ_USE_DMA)) | (RES_IRQ & $past(REQ_USE_DMA))) == 6'h00;
	endproperty
	a_rroute: assert property (p_rroute) else $error("result request misrouted");
	property p_hold;
		RES_RD_VALID[3] && !RES_RD_READY[3] |=> RES_RD_VALID[3] && $stable(RES_RD_DATA[63:48]);
	endproperty
	a_hold: assert property (p_hold) else $error("stalled result not held");
	c_abort: cover property (ADC_ABORT != 2'h0);
	c_frame: cover property ($rose(SER_CS_N));
	c_full: cover property (RES_DMA_REQ != 6'h00);
endmodule : acq_qc_assertions
bind acq_queue_ctrl acq_qc_assertions acq_qc_assertions_i (.CLK(CLK), .SYS_RST(SYS_RST),
	.REQ_USE_DMA(REQ_USE_DMA), .ADC_START(ADC_START), .ADC_ABORT(ADC_ABORT),
	.SER_SCK(SER_SCK), .SER_CS_N(SER_CS_N), .SER_MOSI(SER_MOSI), .CMD_DMA_REQ(CMD_DMA_REQ),
	.CMD_IRQ(CMD_IRQ), .RES_DMA_REQ(RES_DMA_REQ), .RES_IRQ(RES_IRQ),
	.RES_RD_READY(RES_RD_READY), .RES_RD_VALID(RES_RD_VALID), .RES_RD_DATA(RES_RD_DATA));

// File: testbench/tb_top.sv
`timescale 1ns/1ps
`define CHK(n, e, s) begin num_checks++; if ((s) !== (e)) begin failures++; \
	$display("wrong value %s expected %0h seen %0h", n, e, s); end end
module tb_top;
	localparam logic [11:0] SRES = 12'h5A3;
	logic CLK = 1'b0;
	logic SYS_RST = 1'b1;
	logic wv = 1'b0;
	logic [2:0] wq = 3'h0;
	logic [15:0] wd = 16'h0000;
	logic [5:0] sw = 6'h00;
	logic [5:0] hw = 6'h00;
	logic [5:0] dma = 6'h08;
	logic [5:0] rrdy = 6'h3F;
	logic [1:0] dlg = 2'h1;
	logic [5:0] wrdy, cdma, cirq, rdma, rirq, rvld, ch0, ch1, c;
	logic [1:0] st, ab, done;
	logic [11:0] d0, d1;
	logic sck, csn, mosi, miso, ovr, r;
	logic [95:0] rdat;
	logic [31:0] srx;
	logic [31:0] rng = 32'hCE238F8C;
	logic [15:0] e;
	logic [2:0] rq;
	logic [15:0] exq [6][$];
	int failures = 0;
	int num_checks = 0;
	int pend = 0;
	int tmo, n;
	always #12.5 CLK = ~CLK;
	acq_queue_ctrl acq_queue_ctrl_i (.CLK(CLK), .SYS_RST(SYS_RST), .CMD_WR_VALID(wv),
		.CMD_WR_QUEUE(wq), .CMD_WR_DATA(wd), .CMD_WR_READY(wrdy), .SW_TRIG(sw), .HW_TRIG(hw),
		.REQ_USE_DMA(dma), .DECIM_LOG2(dlg), .ADC_START(st), .ADC_ABORT(ab), .ADC_CHAN0(ch0),
		.ADC_CHAN1(ch1), .ADC_DONE(done), .ADC_DATA0(d0), .ADC_DATA1(d1), .SER_SCK(sck),
		.SER_CS_N(csn), .SER_MOSI(mosi), .SER_MISO(miso), .CMD_DMA_REQ(cdma), .CMD_IRQ(cirq),
		.RES_DMA_REQ(rdma), .RES_IRQ(rirq), .RES_RD_READY(rrdy), .RES_RD_VALID(rvld),
		.RES_RD_DATA(rdat), .RES_OVERRUN(ovr));
	acq_conv_model #(.SER_RESULT(SRES)) acq_conv_model_i (.clk(CLK), .rst(SYS_RST), .start(st),
		.chan0(ch0), .chan1(ch1), .done(done), .data0(d0), .data1(d1), .sck(sck), .cs_n(csn),
		.mosi(mosi), .miso(miso), .rx(srx));
	function automatic logic [31:0] xs();
		rng ^= rng << 13;
		rng ^= rng >> 17;
		rng ^= rng << 5;
		return rng;
	endfunction : xs
	function automatic logic [15:0] ev(input logic [1:0] s, input logic [5:0] ch);
		return {s, 2'h0, ch, ch ^ 6'h2A};
	endfunction : ev
	function automatic logic [15:0] cm(input logic x, a, input logic [5:0] ch,
		input logic [2:0] q, input logic dc);
		return {x, a, ch, q, dc, 4'(xs())};
	endfunction : cm
	task automatic test_done();
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : test_done
	task automatic note(input int q, input logic [15:0] v);
		exq[q].push_back(v);
		pend++;
	endtask : note
	task automatic wr(input logic [2:0] q, input logic [15:0] d);
		wq <= q;
		wd <= d;
		wv <= 1'b1;
		for (tmo = 0; tmo < 50; tmo++) begin
			@(negedge CLK);
			r = wrdy[q];
			@(posedge CLK);
			if (r) break;
		end
		wv <= 1'b0;
		`CHK("write taken", 1'b1, r)
		if (!r) test_done();
		@(posedge CLK);
	endtask : wr
	task automatic trg(input int q, input logic h);
		if (h) hw[q] <= 1'b1;
		else sw[q] <= 1'b1;
		@(posedge CLK);
		hw <= 6'h00;
		sw <= 6'h00;
	endtask : trg
	task automatic drain(input int lim);
		for (tmo = 0; tmo < lim && pend != 0; tmo++) @(posedge CLK);
		`CHK("pending results", 0, pend)
		if (pend != 0) test_done();
	endtask : drain
	// Results are compared in arrival order within each result queue.
	always @(posedge CLK) begin
		if (!SYS_RST) `CHK("overrun", 1'b0, ovr)
		for (int q = 0; q < 6; q++) begin
			if (!SYS_RST && rvld[q] === 1'b1 && rrdy[q]) begin
				e = exq[q].size() != 0 ? exq[q].pop_front() : 16'hXXXX;
				pend--;
				`CHK("result word", e, rdat[q*16 +: 16])
			end
		end
	end
	initial begin
		repeat (8) @(posedge CLK);
		SYS_RST <= 1'b0;
		repeat (2) @(posedge CLK);
		@(negedge CLK);
		`CHK("write ready", 6'h3F, wrdy)
		`CHK("command irq", ~dma, cirq)
		`CHK("command dma", dma, cdma)
		@(posedge CLK);
		$display("test reset done");
		for (int i = 0; i < 6; i++) begin
			c = i == 0 ? 6'h00 : i == 1 ? 6'h3F : 6'(xs());
			rq = 3'(xs() % 6);
			note(rq, ev({1'b0, i[0]}, c));
			wr(3'(1 + i % 5), cm(1'b0, i[0], c, rq, 1'b0));
			trg(1 + i % 5, i[1]);
			drain(100);
		end
		$display("test channels done");
		wr(3'h4, cm(1'b0, 1'b0, 6'h05, 3'h0, 1'b0));
		trg(4, 1'b0);
		wr(3'h5, cm(1'b0, 1'b0, 6'h07, 3'h0, 1'b0));
		wr(3'h3, cm(1'b0, 1'b0, 6'h09, 3'h0, 1'b0));
		sw <= 6'h28;
		@(posedge CLK);
		sw <= 6'h00;
		note(0, ev(2'h0, 6'h05));
		note(0, ev(2'h0, 6'h09));
		note(0, ev(2'h0, 6'h07));
		drain(200);
		$display("test priority done");
		for (int b = 1; b >= 0; b--) begin
			if (b) begin
				wr(3'h4, cm(1'b0, 1'b1, 6'h03, 3'h2, 1'b0));
				trg(4, 1'b1);
				repeat (4) @(posedge CLK);
			end
			wr(3'h0, cm(1'b0, 1'b1, 6'h0C, 3'h2, 1'b0));
			note(2, ev(2'h1, 6'h0C));
			repeat (3) @(posedge CLK);
			trg(0, 1'b0);
			@(negedge CLK);
			`CHK("start", 2'h2, st)
			`CHK("abort", {b[0], 1'b0}, ab)
			@(posedge CLK);
			drain(100);
		end
		$display("test preempt done");
		wr(3'h1, cm(1'b1, 1'b0, 6'h11, 3'h4, 1'b0));
		wr(3'h2, cm(1'b1, 1'b1, 6'h22, 3'h4, 1'b0));
		note(4, {2'h2, 2'h0, SRES});
		note(4, {2'h2, 2'h0, SRES});
		sw <= 6'h06;
		@(posedge CLK);
		sw <= 6'h00;
		drain(1000);
		`CHK("frame bits", {wd, 16'h0000}, srx)
		$display("test serial done");
		rrdy <= 6'h37;
		n = 0;
		for (int k = 0; k < 20; k++) begin
			c = 6'(xs());
			wq <= 3'h5;
			wd <= cm(1'b0, 1'b0, c, 3'h3, 1'b0);
			wv <= 1'b1;
			@(negedge CLK);
			r = wrdy[5];
			@(posedge CLK);
			if (r) begin
				note(3, ev(2'h0, c));
				n++;
			end
		end
		wv <= 1'b0;
		@(negedge CLK);
		`CHK("queue refuses", 1'b0, wrdy[5])
		`CHK("accepted in range", 1'b1, n >= 15 && n <= 17)
		`CHK("command irq full", 1'b0, cirq[5])
		@(posedge CLK);
		trg(5, 1'b0);
		for (tmo = 0; tmo < 800 && rdma[3] !== 1'b1; tmo++) @(posedge CLK);
		@(negedge CLK);
		`CHK("result dma", 1'b1, rdma[3])
		`CHK("result irq", 1'b0, rirq[3])
		if (rdma[3] !== 1'b1) test_done();
		@(posedge CLK);
		rrdy <= 6'h3F;
		drain(1000);
		@(negedge CLK);
		`CHK("command irq empty", 1'b1, cirq[5])
		@(posedge CLK);
		$display("test buffer done");
		wr(3'h2, cm(1'b0, 1'b0, 6'h15, 3'h1, 1'b1));
		wr(3'h2, cm(1'b0, 1'b0, 6'h15, 3'h1, 1'b1));
		note(1, ev(2'h3, 6'h15));
		trg(2, 1'b1);
		drain(300);
		dlg <= 2'h0;
		wr(3'h2, cm(1'b0, 1'b1, 6'h2C, 3'h5, 1'b1));
		note(5, ev(2'h3, 6'h2C));
		trg(2, 1'b0);
		drain(300);
		$display("test decimation done");
		test_done();
	end
endmodule : tb_top
